// >>> bench/dbg_host_model.sv
// Model of the external debugger and scan tester on the shared pins
`timescale 1ns/1ps
module dbg_host_model
  import dbg_port_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_data_out,
  input  wire logic i_data_oe_n,
  output pins_s     o_pins
);
  // 200 ns a bit, well below a fifth of the clock rate
  localparam int HALF = 4;

  pins_s p = 4'b0111;
  assign o_pins = p;

  // One bit on either link clock; seen = {oe_n, data} just before the rise
  task automatic clk_bit(input logic ser, input logic tms, input logic din,
                         output logic [1:0] seen);
    @(negedge i_clk);
    if (ser) p.serial_clock = 1'b0;
    else p.test_clock = 1'b0;
    p.mode_select = tms;
    p.serial_in = din;
    repeat (HALF) @(negedge i_clk);
    seen = {i_data_oe_n, i_data_out};
    if (ser) p.serial_clock = 1'b1;
    else p.test_clock = 1'b1;
    repeat (HALF - 1) @(negedge i_clk);
  endtask

  // oe[1]: any release while shifting, oe[0]: release seen back in idle
  task automatic scan(input logic ir, input logic [BSR_W-1:0] din,
                      output logic [BSR_W-1:0] dout, output logic [1:0] oe);
    logic [1:0] s;
    oe = 2'b00;
    clk_bit(1'b0, 1'b1, 1'b1, s);
    if (ir) clk_bit(1'b0, 1'b1, 1'b1, s);
    clk_bit(1'b0, 1'b0, 1'b1, s);
    clk_bit(1'b0, 1'b0, 1'b1, s);
    for (int i = 0; i < BSR_W; i++) begin
      clk_bit(1'b0, i == BSR_W - 1, din[i], s);
      dout[i] = s[0];
      oe[1] = oe[1] | s[1];
    end
    clk_bit(1'b0, 1'b1, 1'b1, s);
    clk_bit(1'b0, 1'b0, 1'b1, s);
    clk_bit(1'b0, 1'b0, 1'b1, s);
    oe[0] = s[1];
    p.serial_in = ~p.serial_in;
  endtask

  task automatic frame(input logic [CMD_W-1:0] cmd, output logic [CMD_W-1:0] back);
    logic [1:0] s;
    for (int i = CMD_W - 1; i >= 0; i--) begin
      clk_bit(1'b1, 1'b1, cmd[i], s);
      back[i] = s[0];
    end
    // Released line shows the inverse, not a stale bit
    p.serial_in = ~p.serial_in;
  endtask
endmodule

// >>> bench/dbg_port_tb.sv
// Self-checking bench for the shared debug and test port
`timescale 1ns/1ps
module dbg_port_tb;
  import dbg_port_pkg::*;
  logic               clk = 1'b0;
  logic               rstn = 1'b0;
  logic               strap = 1'b0;
  pins_s              pins;
  logic               data_out, oe_n, jtag_mode, breakpoint_request, cmd_valid, extest;
  logic [CMD_W-1:0]   cmd;
  logic [CMD_W-1:0]   resp = '0;
  trace_s             core_trace = '0;
  trace_s             trace;
  logic [BSR_W-1:0]   bsr_cap = '0;
  logic [BSR_W-1:0]   bsr_upd;
  logic [CMD_W-1:0]   cmd_q[$];
  logic [1:0]         oe_chk;
  int                 error_cnt = 0;
  int                 samples_checked = 0;

  always #12.5 clk = ~clk;

  dbg_port uut (
    .I_CLK(clk), .I_RSTN(rstn), .I_MODE_STRAP(strap), .I_PINS(pins),
    .O_PIN_DATA_OUT(data_out), .O_PIN_DATA_OE_N(oe_n), .O_JTAG_MODE(jtag_mode),
    .O_BREAKPOINT_REQUEST(breakpoint_request), .O_DBG_CMD(cmd), .O_DBG_CMD_VALID(cmd_valid),
    .I_DBG_RESP(resp), .I_CORE_TRACE(core_trace), .O_TRACE(trace),
    .I_BSR_CAPTURE(bsr_cap), .O_BSR_UPDATE(bsr_upd), .O_EXTEST(extest));

  dbg_host_model host (
    .i_clk(clk), .i_data_out(data_out), .i_data_oe_n(oe_n), .o_pins(pins));

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checked=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic end_test(input string n);
    $display("test %s done", n);
  endtask

  task automatic do_reset(input logic s);
    @(negedge clk);
    rstn = 1'b0;
    strap = s;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    compare(32'(jtag_mode), 32'(s));
  endtask

  task automatic wait_breakpoint_request(input logic lvl);
    for (int i = 0; i < 8 && breakpoint_request !== lvl; i++) @(negedge clk);
    compare(32'(breakpoint_request), 32'(lvl));
  endtask

  // Each command pulse takes the oldest expected frame
  always @(negedge clk) begin
    if (cmd_valid === 1'b1)
      compare(32'(cmd), cmd_q.size() > 0 ? 32'(cmd_q.pop_front()) : 'x);
  end

  initial begin
    repeat (60000) @(negedge clk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    logic [BSR_W-1:0] dout, c, d;
    logic [1:0]       s;
    logic [CMD_W-1:0] back, prev, c17;
    trace_s           exp;
    void'($urandom(41));
    do_reset(1'b0);
    host.p.mode_select = 1'b0;
    wait_breakpoint_request(1'b1);
    host.p.mode_select = 1'b1;
    wait_breakpoint_request(1'b0);
    // Test clock must not disturb the serial personality
    host.clk_bit(1'b0, 1'b1, 1'b1, s);
    compare(32'(s[1]), 32'h0);
    end_test("breakpoint");
    for (int f = 0; f < 4; f++) begin
      repeat (2) @(negedge clk);
      c17 = CMD_W'($urandom);
      cmd_q.push_back(c17);
      resp = CMD_W'($urandom);
      host.frame(c17, back);
      if (f > 0) compare(32'(back), 32'(prev));
      prev = resp;
    end
    repeat (8) @(negedge clk);
    compare(32'(cmd_q.size()), 32'h0);
    end_test("serial");
    for (int k = 0; k < 24; k++) begin
      exp = trace_s'(8'($urandom));
      if (k < 16) exp.core_status_code = 4'(k);
      core_trace = exp;
      @(negedge clk);
      if (exp.core_status_code inside {PST_RSVD_A, PST_RSVD_B})
        exp.core_status_code = PST_CONTINUE;
      compare(32'(trace), 32'(exp));
    end
    end_test("trace");
    do_reset(1'b1);
    // Park in shift, then five ones must still reach reset
    for (int i = 0; i < 10; i++) host.clk_bit(1'b0, 1'(10'b0111110010 >> i), 1'b1, s);
    host.scan(1'b1, {IR_SAMPLE, 4'ha}, dout, oe_chk);
    compare(32'(dout), 32'({4'ha, IR_CAPTURE_VAL}));
    compare(32'(oe_chk), 32'h1);
    compare(32'(extest), 32'h0);
    c = BSR_W'($urandom);
    d = BSR_W'($urandom);
    bsr_cap = c;
    host.scan(1'b0, d, dout, oe_chk);
    compare(32'(dout), 32'(c));
    compare(32'(bsr_upd), 32'(d));
    // Long stall with the test clock parked high
    repeat (300) @(negedge clk);
    host.scan(1'b1, {IR_EXTEST, 4'h5}, dout, oe_chk);
    compare(32'(dout), 32'({4'h5, IR_CAPTURE_VAL}));
    compare(32'(extest), 32'h1);
    end_test("scan");
    host.p.serial_clock = 1'b0;
    repeat (4) @(negedge clk);
    compare(32'({oe_n, extest}), 32'h2);
    host.p.mode_select = 1'b1;
    @(negedge clk);
    host.p.serial_clock = 1'b1; // released while mode select is high
    host.clk_bit(1'b0, 1'b0, 1'b1, s);
    host.scan(1'b0, ~d, dout, oe_chk);
    compare(32'(dout), 32'({~d[BSR_W-2:0], 1'b0}));
    // Test reset clears the update register; bypass scan leaves it clear
    compare(32'(bsr_upd), 32'h0);
    end_test("test_reset");
    report_and_stop();
  end
endmodule

// >>> hdl/dbg_port.sv
// Shared debug port: test access controller and serial debug link
`timescale 1ns/1ps
module dbg_port
  import dbg_port_pkg::*;
#(
  parameter int BSR_LEN = BSR_W,
  parameter int CMD_LEN = CMD_W
) (
  input  wire logic               I_CLK,
  input  wire logic               I_RSTN,
  input  wire logic               I_MODE_STRAP,
  input  wire pins_s              I_PINS,
  output logic                    O_PIN_DATA_OUT,
  output logic                    O_PIN_DATA_OE_N,
  output logic                    O_JTAG_MODE,
  output logic                    O_BREAKPOINT_REQUEST,
  output logic [CMD_LEN-1:0]      O_DBG_CMD,
  output logic                    O_DBG_CMD_VALID,
  input  wire logic [CMD_LEN-1:0] I_DBG_RESP,
  input  wire trace_s             I_CORE_TRACE,
  output trace_s                  O_TRACE,
  input  wire logic [BSR_LEN-1:0] I_BSR_CAPTURE,
  output logic [BSR_LEN-1:0]      O_BSR_UPDATE,
  output logic                    O_EXTEST
);

  logic [SYNC_W-1:0] s_lvl;
  logic [SYNC_W-1:0] s_rise;
  logic [SYNC_W-1:0] s_fall;

  dbg_sync #(.W(SYNC_W)) u_sync (
    .i_clk   (I_CLK),
    .i_rstn  (I_RSTN),
    .i_async ({I_MODE_STRAP, I_PINS}),
    .o_level (s_lvl),
    .o_rise  (s_rise),
    .o_fall  (s_fall)
  );

  logic strap_s, tms_s, tdi_s, tck_rise, tck_fall, debug_serial_clock_rise;
  assign strap_s    = s_lvl[4];
  assign tms_s      = s_lvl[2];
  assign tdi_s      = s_lvl[1];
  assign tck_rise   = s_rise[3];
  assign tck_fall   = s_fall[3];
  assign debug_serial_clock_rise = s_rise[0];

  // System group: strap capture, serial debug link, trace outputs
  logic               jtag_mode_r, jtag_mode_nxt;
  logic               strap_done_r, strap_done_nxt;
  logic [1:0]         strap_cnt_r, strap_cnt_nxt;
  logic [CMD_LEN-1:0] cmd_sh_r, cmd_sh_nxt;
  logic [CMD_LEN-1:0] resp_sh_r, resp_sh_nxt;
  logic [4:0]         bit_cnt_r, bit_cnt_nxt;
  logic               cmd_valid_r, cmd_valid_nxt;
  logic [CMD_LEN-1:0] cmd_r, cmd_nxt;
  logic               breakpoint_request_r, breakpoint_request_nxt;
  trace_s             trace_r, trace_nxt;

  always_comb begin
    jtag_mode_nxt  = jtag_mode_r;
    strap_done_nxt = strap_done_r;
    strap_cnt_nxt  = strap_cnt_r;
    cmd_sh_nxt     = cmd_sh_r;
    resp_sh_nxt    = resp_sh_r;
    bit_cnt_nxt    = bit_cnt_r;
    cmd_valid_nxt  = 1'b0;
    cmd_nxt        = cmd_r;
    // Sync stages reset to one, so wait until both hold the real strap
    if (!strap_done_r) begin
      strap_cnt_nxt = strap_cnt_r + 2'd1;
      if (strap_cnt_r == 2'd2) begin
        jtag_mode_nxt  = strap_s;
        strap_done_nxt = 1'b1;
      end
    end
    breakpoint_request_nxt = !jtag_mode_r && strap_done_r && !tms_s;
    if (!jtag_mode_r && strap_done_r && debug_serial_clock_rise) begin
      cmd_sh_nxt  = {cmd_sh_r[CMD_LEN-2:0], tdi_s};
      resp_sh_nxt = {resp_sh_r[CMD_LEN-2:0], 1'b0};
      if (bit_cnt_r == 5'(CMD_LEN - 1)) begin
        bit_cnt_nxt   = '0;
        cmd_valid_nxt = 1'b1;
        cmd_nxt       = {cmd_sh_r[CMD_LEN-2:0], tdi_s};
        resp_sh_nxt   = I_DBG_RESP;
      end else begin
        bit_cnt_nxt = bit_cnt_r + 5'd1;
      end
    end
    // Reserved codes never reach the pins
    trace_nxt = I_CORE_TRACE;
    if (I_CORE_TRACE.core_status_code == PST_RSVD_A ||
        I_CORE_TRACE.core_status_code == PST_RSVD_B)
      trace_nxt.core_status_code = PST_CONTINUE;
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      jtag_mode_r  <= 1'b0;
      strap_done_r <= 1'b0;
      strap_cnt_r  <= '0;
      cmd_sh_r     <= '0;
      resp_sh_r    <= '0;
      bit_cnt_r    <= '0;
      cmd_valid_r  <= 1'b0;
      cmd_r        <= '0;
      breakpoint_request_r       <= 1'b0;
      trace_r      <= '0;
    end else begin
      jtag_mode_r  <= jtag_mode_nxt;
      strap_done_r <= strap_done_nxt;
      strap_cnt_r  <= strap_cnt_nxt;
      cmd_sh_r     <= cmd_sh_nxt;
      resp_sh_r    <= resp_sh_nxt;
      bit_cnt_r    <= bit_cnt_nxt;
      cmd_valid_r  <= cmd_valid_nxt;
      cmd_r        <= cmd_nxt;
      breakpoint_request_r       <= breakpoint_request_nxt;
      trace_r      <= trace_nxt;
    end
  end

  // Test group: the pin reset is also the serial clock, so gate it by mode
  logic tap_rst_n;
  assign tap_rst_n = I_RSTN && !(jtag_mode_r && !I_PINS.serial_clock);

  tap_state_e         st_r, st_nxt;
  logic [IR_W-1:0]    ir_r, ir_nxt;
  logic [IR_W-1:0]    ir_sh_r, ir_sh_nxt;
  logic [BSR_LEN-1:0] bsr_r, bsr_nxt;
  logic [BSR_LEN-1:0] upd_r, upd_nxt;
  logic               byp_r, byp_nxt;
  logic               tdo_r, tdo_nxt;
  logic               oe_n_r, oe_n_nxt;
  logic               tap_step;
  logic               sel_bit;

  assign tap_step = jtag_mode_r && tck_rise;

  always_comb begin
    st_nxt    = st_r;
    ir_nxt    = ir_r;
    ir_sh_nxt = ir_sh_r;
    bsr_nxt   = bsr_r;
    upd_nxt   = upd_r;
    byp_nxt   = byp_r;
    tdo_nxt   = tdo_r;
    oe_n_nxt  = oe_n_r;
    sel_bit   = (ir_r == IR_BYPASS) ? byp_r : bsr_r[0];
    if (tap_step) begin
      case (st_r)
        TLR:     st_nxt = tms_s ? TLR    : RTI;
        RTI:     st_nxt = tms_s ? SEL_DR : RTI;
        SEL_DR:  st_nxt = tms_s ? SEL_IR : CAP_DR;
        CAP_DR:  st_nxt = tms_s ? EX1_DR : SH_DR;
        SH_DR:   st_nxt = tms_s ? EX1_DR : SH_DR;
        EX1_DR:  st_nxt = tms_s ? UPD_DR : PAU_DR;
        PAU_DR:  st_nxt = tms_s ? EX2_DR : PAU_DR;
        EX2_DR:  st_nxt = tms_s ? UPD_DR : SH_DR;
        UPD_DR:  st_nxt = tms_s ? SEL_DR : RTI;
        SEL_IR:  st_nxt = tms_s ? TLR    : CAP_IR;
        CAP_IR:  st_nxt = tms_s ? EX1_IR : SH_IR;
        SH_IR:   st_nxt = tms_s ? EX1_IR : SH_IR;
        EX1_IR:  st_nxt = tms_s ? UPD_IR : PAU_IR;
        PAU_IR:  st_nxt = tms_s ? EX2_IR : PAU_IR;
        EX2_IR:  st_nxt = tms_s ? UPD_IR : SH_IR;
        UPD_IR:  st_nxt = tms_s ? SEL_DR : RTI;
        default: st_nxt = TLR;
      endcase
      case (st_r)
        TLR:     ir_nxt = IR_BYPASS;
        CAP_IR:  ir_sh_nxt = IR_CAPTURE_VAL;
        SH_IR:   ir_sh_nxt = {tdi_s, ir_sh_r[IR_W-1:1]};
        UPD_IR:  ir_nxt = ir_sh_r;
        CAP_DR: begin
          byp_nxt = 1'b0;
          if (ir_r != IR_BYPASS)
            bsr_nxt = I_BSR_CAPTURE;
        end
        SH_DR: begin
          if (ir_r == IR_BYPASS)
            byp_nxt = tdi_s;
          else
            bsr_nxt = {tdi_s, bsr_r[BSR_LEN-1:1]};
        end
        UPD_DR: begin
          if (ir_r != IR_BYPASS)
            upd_nxt = bsr_r;
        end
        default: ;
      endcase
    end
    // Output moves only on the falling test clock
    if (jtag_mode_r && tck_fall) begin
      tdo_nxt  = (st_r == SH_IR) ? ir_sh_r[0] : sel_bit;
      oe_n_nxt = !(st_r == SH_IR || st_r == SH_DR);
    end
  end

  always_ff @(posedge I_CLK or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      st_r    <= TLR;
      ir_r    <= IR_BYPASS;
      ir_sh_r <= '0;
      bsr_r   <= '0;
      upd_r   <= '0;
      byp_r   <= 1'b0;
      tdo_r   <= 1'b0;
      oe_n_r  <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      ir_r    <= ir_nxt;
      ir_sh_r <= ir_sh_nxt;
      bsr_r   <= bsr_nxt;
      upd_r   <= upd_nxt;
      byp_r   <= byp_nxt;
      tdo_r   <= tdo_nxt;
      oe_n_r  <= oe_n_nxt;
    end
  end

  // Serial debug drives the pin at all times
  assign O_PIN_DATA_OUT       = jtag_mode_r ? tdo_r : resp_sh_r[CMD_LEN-1];
  assign O_PIN_DATA_OE_N      = jtag_mode_r ? oe_n_r : 1'b0;
  assign O_JTAG_MODE          = jtag_mode_r;
  assign O_BREAKPOINT_REQUEST = breakpoint_request_r;
  assign O_DBG_CMD            = cmd_r;
  assign O_DBG_CMD_VALID      = cmd_valid_r;
  assign O_TRACE              = trace_r;
  assign O_BSR_UPDATE         = upd_r;
  assign O_EXTEST             = (ir_r == IR_EXTEST);

  // Helper: consecutive test clock rises with mode select high
  logic [2:0] tms_ones_r;
  always_ff @(posedge I_CLK or negedge tap_rst_n) begin
    if (!tap_rst_n)
      tms_ones_r <= '0;
    else if (tap_step)
      tms_ones_r <= !tms_s ? 3'd0 : (tms_ones_r == 3'd7 ? 3'd7 : tms_ones_r + 3'd1);
  end

  sequence s_last_bit;
    !jtag_mode_r && strap_done_r && debug_serial_clock_rise && bit_cnt_r == 5'(CMD_LEN - 1);
  endsequence
  sequence s_cmd_out;
    O_DBG_CMD_VALID ##1 !O_DBG_CMD_VALID;
  endsequence

  property p_strap_hold;
    @(posedge I_CLK) disable iff (!I_RSTN) strap_done_r |=> $stable(jtag_mode_r);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("Mode changed after strap");

  property p_trst;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (jtag_mode_r && !I_PINS.serial_clock) |-> (st_r == TLR && ir_r == IR_BYPASS);
  endproperty
  a_trst: assert property (p_trst) else $error("Test reset did not force reset state");

  property p_five_clocks;
    @(posedge I_CLK) disable iff (!tap_rst_n)
      tms_ones_r >= 3'(TLR_TMS_CLOCKS) |-> st_r == TLR;
  endproperty
  a_five_clocks: assert property (p_five_clocks) else $error("No reset after five clocks");

  property p_step;
    @(posedge I_CLK) disable iff (!tap_rst_n)
      (tap_step && st_r == SEL_DR) |=> st_r == ($past(tms_s) ? SEL_IR : CAP_DR);
  endproperty
  a_step: assert property (p_step) else $error("Wrong controller step");

  property p_idle_hold;
    @(posedge I_CLK) disable iff (!tap_rst_n) !tap_step |=> $stable(st_r) && $stable(ir_r);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("Test state moved without clock");

  property p_shift_in;
    @(posedge I_CLK) disable iff (!tap_rst_n)
      (tap_step && st_r == SH_IR) |=> ir_sh_r[IR_W-1] == $past(tdi_s);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("Data not shifted in");

  property p_tdo_fall;
    @(posedge I_CLK) disable iff (!tap_rst_n)
      (jtag_mode_r && !tck_fall) |=> $stable(O_PIN_DATA_OUT) && $stable(O_PIN_DATA_OE_N);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("Test output moved off falling clock");

  property p_tdo_release;
    @(posedge I_CLK) disable iff (!tap_rst_n)
      (jtag_mode_r && tck_fall && st_r != SH_DR && st_r != SH_IR) |=> O_PIN_DATA_OE_N;
  endproperty
  a_tdo_release: assert property (p_tdo_release) else $error("Output driven while idle");

  property p_breakpoint_request;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (!jtag_mode_r && strap_done_r && !tms_s) |=> O_BREAKPOINT_REQUEST;
  endproperty
  a_breakpoint_request: assert property (p_breakpoint_request) else $error("Breakpoint not requested");

  property p_cmd;
    @(posedge I_CLK) disable iff (!I_RSTN) s_last_bit |=> s_cmd_out;
  endproperty
  a_cmd: assert property (p_cmd) else $error("Command not delivered");

  property p_status;
    @(posedge I_CLK) disable iff (!I_RSTN)
      (I_CORE_TRACE.core_status_code != PST_RSVD_A &&
       I_CORE_TRACE.core_status_code != PST_RSVD_B)
      |=> O_TRACE.core_status_code == $past(I_CORE_TRACE.core_status_code);
  endproperty
  a_status: assert property (p_status) else $error("Status code not registered");

  property p_trace;
    @(posedge I_CLK) disable iff (!I_RSTN)
      1'b1 |=> O_TRACE.debug_trace_data == $past(I_CORE_TRACE.debug_trace_data);
  endproperty
  a_trace: assert property (p_trace) else $error("Trace data not registered");

endmodule

// >>> hdl/dbg_port_pkg.sv
// Constants, states and carrier types for the shared debug and test port
// Summary of operation
// - Strap at reset picks serial debug or test
// - Test reset forces reset state and bypass
// - Five clocks with mode high reach reset
// - Controller holds or advances on rising clock
// - Test data shifts into selected register rising
// - Test data out changes on falling clock
// - Test data out released when not shifting
// - Test logic keeps state while clock stalls
// - Breakpoint input requests processor breakpoint
// - Commands in, responses out, one bit each
// - Status code registered on processor clock
// - Status codes zero through seven as listed
// - Codes eight up announce transfers and halts
// - Trace data shows addresses, data, breakpoint
package dbg_port_pkg;

  localparam int          IR_W           = 4;
  localparam logic [3:0]  IR_EXTEST      = 4'h0;
  localparam logic [3:0]  IR_SAMPLE      = 4'h1;
  localparam logic [3:0]  IR_BYPASS      = 4'hf;
  localparam logic [3:0]  IR_CAPTURE_VAL = 4'h1;
  localparam int          BSR_W          = 8;
  localparam int          CMD_W          = 17;
  localparam int          TLR_TMS_CLOCKS = 5;
  localparam int          SYNC_W         = 5;

  localparam logic [3:0]  PST_CONTINUE   = 4'h0;
  localparam logic [3:0]  PST_RSVD_A     = 4'h2;
  localparam logic [3:0]  PST_RSVD_B     = 4'h6;

  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } tap_state_e;

  // Pins shared between the two personalities
  typedef struct packed {
    logic test_clock;
    logic mode_select;
    logic serial_in;
    logic serial_clock;
  } pins_s;

  typedef struct packed {
    logic [3:0] core_status_code;
    logic [3:0] debug_trace_data;
  } trace_s;

endpackage

// >>> hdl/dbg_sync.sv
// Two-flop synchroniser with edge detection for a group of pins
`timescale 1ns/1ps
module dbg_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // Reset to one matches the pull-ups on the pins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= '1;
      sync_r <= '1;
      prev_r <= '1;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_level = sync_r;
  assign o_rise  = sync_r & ~prev_r;
  assign o_fall  = ~sync_r & prev_r;

endmodule
